// ==== hw/conv_channel_latch.sv ====
// Converter input latch of one channel with its update trigger selection
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module conv_channel_latch (
    input  wire logic                             clk_sys_in,
    input  wire logic                             rstn_in,
    input  wire dac_update_pkg::conv_ctrl_type    ctrl_in,
    input  wire logic [7:0]                       high_in,
    input  wire logic [7:0]                       low_in,
    input  wire logic                             high_wr_in,
    input  wire logic [7:0]                       high_wdata_in,
    input  wire dac_update_pkg::timer_strobe_type strobes_in,
    output logic [11:0]                           code_out
);
    import dac_update_pkg::*;

    logic        on_write;
    logic        timer_hit;
    logic        load_now;
    logic [7:0]  load_high;
    logic [11:0] next_code;

    assign on_write  = (ctrl_in.mode == MODE_ON_WRITE);
    // Relies on single-cycle strobes so one overflow loads once [R17]
    assign timer_hit = select_strobe(ctrl_in.mode, strobes_in);
    // In write mode only the high byte write loads; low byte writes just wait [R7] [R13]
    assign load_now  = on_write ? high_wr_in : timer_hit; // [R14]
    // Write mode uses the byte being written so the new value shows at once
    assign load_high = on_write ? high_wdata_in : high_in;
    assign next_code = assemble_word(ctrl_in.format, load_high, low_in); // [R1]

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            code_out <= `CONV_CODE_RESET;
        end else if (load_now) begin
            code_out <= next_code; // [R15]
        end
    end

endmodule : conv_channel_latch

// ==== hw/dac_update_defines.svh ====
// Register map, field positions and reset values of the dual converter update block
// Overview of operation
// [R1] Control bits 2:0 pick one of five word placements across high and low bytes.
// [R2] Format 000: word is high[3:0] then the whole low byte.
// [R3] Format 001: word is high[4:0] then low[7:1].
// [R4] Format 010: word is high[5:0] then low[7:2].
// [R5] Format 011: word is high[6:0] then low[7:3].
// [R6] Format 1xx: word is the whole high byte then low[7:4].
// [R7] Mode 00 loads the converter latch when software writes the high byte.
// [R8] Modes 01, 10, 11 load the latch on timer 3, 4, 2 overflow.
// [R9] Control bit 7 enables the channel output; zero means pin off, shutdown.
// [R10] Control bits 6:5 read as zero and ignore written values.
// [R11] Second channel behaves like the first with its own fields and bytes.
// [R12] Both control registers share one address; page 0 or 1 picks the channel.
// [R13] Low byte write alone never changes the output; write low before high.
// [R14] Timer modes hold both bytes, latching their combination only on overflow.
// [R15] Latched code is 12-bit unsigned, 000 through fff.
// [R16] After reset control reads zero: disabled, write mode, format 000.
// [R17] Timer logic gives a one-cycle, clock-synchronous overflow strobe per timer.
`ifndef DAC_UPDATE_DEFINES_SVH
`define DAC_UPDATE_DEFINES_SVH

`define CONV_ADDR_LOW      8'hd2
`define CONV_ADDR_HIGH     8'hd3
`define CONV_ADDR_CTRL     8'hd4
`define CONV_PAGE_A        8'h00
`define CONV_PAGE_B        8'h01

`define CONV_LOW_RESET     8'h00
`define CONV_HIGH_RESET    8'h00
`define CONV_CTRL_RESET    8'h00
`define CONV_CODE_RESET    12'h000
`define CONV_RDATA_RESET   8'h00

`define CTRL_ENABLE_BIT    7
`define CTRL_MODE_MSB      4
`define CTRL_MODE_LSB      3
`define CTRL_FORMAT_MSB    2
`define CTRL_FORMAT_LSB    0
`define CTRL_WRITE_MASK    8'h9f

`endif

// ==== hw/dac_update_pkg.sv ====
// Types and the word placement function of the dual converter update block
package dac_update_pkg;

    typedef enum logic [1:0] {
        MODE_ON_WRITE = 2'b00,
        MODE_TIMER3   = 2'b01,
        MODE_TIMER4   = 2'b10,
        MODE_TIMER2   = 2'b11
    } update_mode_type;

    typedef struct packed {
        logic            enable;
        logic [1:0]      unused;
        update_mode_type mode;
        logic [2:0]      format;
    } conv_ctrl_type;

    typedef struct packed {
        logic       timer2;
        logic       timer3;
        logic       timer4;
    } timer_strobe_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_type;

    // Places the 12-bit word out of the two data bytes
    function automatic logic [11:0] assemble_word(input logic [2:0] format,
                                                  input logic [7:0] high,
                                                  input logic [7:0] low);
        logic [11:0] word;
        word = 12'h000;
        casez (format)
            3'b000:  word = {high[3:0], low[7:0]}; // [R2]
            3'b001:  word = {high[4:0], low[7:1]}; // [R3]
            3'b010:  word = {high[5:0], low[7:2]}; // [R4]
            3'b011:  word = {high[6:0], low[7:3]}; // [R5]
            default: word = {high[7:0], low[7:4]}; // [R6]
        endcase
        return word;
    endfunction : assemble_word

    function automatic logic select_strobe(input update_mode_type mode,
                                           input timer_strobe_type strobes);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            MODE_ON_WRITE: hit = 1'b0;
            MODE_TIMER3:   hit = strobes.timer3; // [R8]
            MODE_TIMER4:   hit = strobes.timer4; // [R8]
            MODE_TIMER2:   hit = strobes.timer2; // [R8]
        endcase
        return hit;
    endfunction : select_strobe

endpackage : dac_update_pkg

// ==== hw/dual_dac_data_update_control.sv ====
// Register file and two channel latches of the dual converter update block
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module dual_dac_data_update_control (
    input  wire logic                             clk_sys_in,
    input  wire logic                             rstn_in,
    input  wire dac_update_pkg::sfr_req_type      sfr_req_in,
    input  wire dac_update_pkg::timer_strobe_type strobes_in,
    output logic [7:0]                            sfr_rdata_out,
    output logic                                  sfr_rvalid_out,
    output logic [11:0]                           converter_channel_a_code_out,
    output logic [11:0]                           converter_channel_b_code_out,
    output logic                                  conv0_enable_out,
    output logic                                  conv1_enable_out
);
    import dac_update_pkg::*;

    // Channel selection by register page [R12]
    logic          page_a;
    logic          page_b;
    logic          at_low;
    logic          at_high;
    logic          at_ctrl;
    logic          mapped;

    logic          wr_low_a;
    logic          wr_high_a;
    logic          wr_ctrl_a;
    logic          wr_low_b;
    logic          wr_high_b;
    logic          wr_ctrl_b;

    logic [7:0]    conv0_data_low_byte;
    logic [7:0]    conv0_data_high_byte;
    conv_ctrl_type conv0_control;
    logic [7:0]    conv1_data_low_byte;
    logic [7:0]    conv1_data_high_byte;
    conv_ctrl_type conv1_control;

    conv_ctrl_type next_ctrl;
    logic [7:0]    read_a;
    logic [7:0]    read_b;
    logic [7:0]    next_rdata;

    assign page_a   = (sfr_req_in.page == `CONV_PAGE_A);
    assign page_b   = (sfr_req_in.page == `CONV_PAGE_B);
    assign at_low   = (sfr_req_in.addr == `CONV_ADDR_LOW);
    assign at_high  = (sfr_req_in.addr == `CONV_ADDR_HIGH);
    assign at_ctrl  = (sfr_req_in.addr == `CONV_ADDR_CTRL);
    assign mapped   = (page_a || page_b) && (at_low || at_high || at_ctrl);

    assign wr_low_a  = sfr_req_in.wr && page_a && at_low;
    assign wr_high_a = sfr_req_in.wr && page_a && at_high;
    assign wr_ctrl_a = sfr_req_in.wr && page_a && at_ctrl; // [R12]
    assign wr_low_b  = sfr_req_in.wr && page_b && at_low;
    assign wr_high_b = sfr_req_in.wr && page_b && at_high;
    assign wr_ctrl_b = sfr_req_in.wr && page_b && at_ctrl; // [R12]

    // Unused control bits are dropped on write so they always read zero [R10]
    assign next_ctrl = conv_ctrl_type'(sfr_req_in.wdata & `CTRL_WRITE_MASK);

    // One byte select serves both pages
    function automatic logic [7:0] read_select(input logic          sel_low,
                                               input logic          sel_high,
                                               input logic          sel_ctrl,
                                               input logic [7:0]    low,
                                               input logic [7:0]    high,
                                               input conv_ctrl_type ctrl);
        logic [7:0] byte_out;
        byte_out = 8'h00;
        if (sel_low) begin
            byte_out = low;
        end else if (sel_high) begin
            byte_out = high;
        end else if (sel_ctrl) begin
            byte_out = 8'(ctrl);
        end
        return byte_out;
    endfunction : read_select

    assign read_a = read_select(at_low, at_high, at_ctrl,
                                conv0_data_low_byte, conv0_data_high_byte, conv0_control);
    assign read_b = read_select(at_low, at_high, at_ctrl,
                                conv1_data_low_byte, conv1_data_high_byte, conv1_control); // [R11]
    // Unmapped addresses answer zero rather than holding the old byte
    assign next_rdata = page_a ? read_a :
                        page_b ? read_b : `CONV_RDATA_RESET;

    // First channel registers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv0_data_low_byte  <= `CONV_LOW_RESET;
            conv0_data_high_byte <= `CONV_HIGH_RESET;
            conv0_control        <= conv_ctrl_type'(`CONV_CTRL_RESET); // [R16]
        end else begin
            if (wr_low_a) begin
                conv0_data_low_byte <= sfr_req_in.wdata; // [R13]
            end
            if (wr_high_a) begin
                conv0_data_high_byte <= sfr_req_in.wdata;
            end
            if (wr_ctrl_a) begin
                conv0_control <= next_ctrl; // [R10]
            end
        end
    end

    // Second channel registers, same layout [R11]
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv1_data_low_byte  <= `CONV_LOW_RESET;
            conv1_data_high_byte <= `CONV_HIGH_RESET;
            conv1_control        <= conv_ctrl_type'(`CONV_CTRL_RESET); // [R16]
        end else begin
            if (wr_low_b) begin
                conv1_data_low_byte <= sfr_req_in.wdata; // [R13]
            end
            if (wr_high_b) begin
                conv1_data_high_byte <= sfr_req_in.wdata;
            end
            if (wr_ctrl_b) begin
                conv1_control <= next_ctrl; // [R10]
            end
        end
    end

    // Read data lands one cycle after the read strobe
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sfr_rdata_out  <= `CONV_RDATA_RESET;
            sfr_rvalid_out <= 1'b0;
        end else begin
            sfr_rdata_out  <= sfr_req_in.rd ? (mapped ? next_rdata : 8'h00) : `CONV_RDATA_RESET;
            sfr_rvalid_out <= sfr_req_in.rd;
        end
    end

    // Enable follows the control bit one cycle later, from its own flop
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv0_enable_out <= 1'b0;
            conv1_enable_out <= 1'b0;
        end else begin
            conv0_enable_out <= conv0_control.enable; // [R9]
            conv1_enable_out <= conv1_control.enable; // [R9] [R11]
        end
    end

    // Latches keep loading while disabled so the code is ready at enable
    conv_channel_latch latch_a (
        .clk_sys_in    (clk_sys_in),
        .rstn_in       (rstn_in),
        .ctrl_in       (conv0_control),
        .high_in       (conv0_data_high_byte),
        .low_in        (conv0_data_low_byte),
        .high_wr_in    (wr_high_a),
        .high_wdata_in (sfr_req_in.wdata),
        .strobes_in    (strobes_in),
        .code_out      (converter_channel_a_code_out)
    );

    conv_channel_latch latch_b (
        .clk_sys_in    (clk_sys_in),
        .rstn_in       (rstn_in),
        .ctrl_in       (conv1_control),
        .high_in       (conv1_data_high_byte),
        .low_in        (conv1_data_low_byte),
        .high_wr_in    (wr_high_b),
        .high_wdata_in (sfr_req_in.wdata),
        .strobes_in    (strobes_in),
        .code_out      (converter_channel_b_code_out)
    );

endmodule : dual_dac_data_update_control

// ==== verification/dual_dac_data_update_control_asserts.sv ====
// Port checks of the dual converter update block
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module dual_dac_data_update_control_asserts (
    input wire logic                             clk_sys_in,
    input wire logic                             rstn_in,
    input wire dac_update_pkg::sfr_req_type      sfr_req_in,
    input wire dac_update_pkg::timer_strobe_type strobes_in,
    input wire logic [7:0]                       sfr_rdata_out,
    input wire logic                             sfr_rvalid_out,
    input wire logic [11:0]                      converter_channel_a_code_out,
    input wire logic [11:0]                      converter_channel_b_code_out,
    input wire logic                             conv0_enable_out,
    input wire logic                             conv1_enable_out
);
    import dac_update_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    wire logic hi_wr   = sfr_req_in.wr && sfr_req_in.addr == `CONV_ADDR_HIGH;
    wire logic ctl_wr  = sfr_req_in.wr && sfr_req_in.addr == `CONV_ADDR_CTRL;
    wire logic quiet_a = !(hi_wr && sfr_req_in.page == `CONV_PAGE_A) && strobes_in == 3'b000;
    wire logic quiet_b = !(hi_wr && sfr_req_in.page == `CONV_PAGE_B) && strobes_in == 3'b000;
    property p_read_answer; sfr_req_in.rd |=> sfr_rvalid_out; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_idle; !sfr_req_in.rd |=> !sfr_rvalid_out && sfr_rdata_out == 8'h00; endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without read");
    property p_unused_zero;
        sfr_rvalid_out && $past(sfr_req_in.addr) == `CONV_ADDR_CTRL |-> sfr_rdata_out[6:5] == 2'b00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");
    property p_enable_a;
        ctl_wr && sfr_req_in.page == `CONV_PAGE_A |-> ##2 conv0_enable_out == $past(sfr_req_in.wdata[7], 2);
    endproperty
    a_enable_a: assert property (p_enable_a) else $error("enable a wrong");
    property p_enable_b;
        ctl_wr && sfr_req_in.page == `CONV_PAGE_B |-> ##2 conv1_enable_out == $past(sfr_req_in.wdata[7], 2);
    endproperty
    a_enable_b: assert property (p_enable_b) else $error("enable b wrong");
    property p_hold_a; quiet_a && $past(quiet_a) |=> $stable(converter_channel_a_code_out); endproperty
    a_hold_a: assert property (p_hold_a) else $error("code a moved");
    property p_hold_b; quiet_b && $past(quiet_b) |=> $stable(converter_channel_b_code_out); endproperty
    a_hold_b: assert property (p_hold_b) else $error("code b moved");
    property p_reset_clear;
        $rose(rstn_in) |-> (converter_channel_a_code_out | converter_channel_b_code_out) == 12'h000
            && !conv0_enable_out && !conv1_enable_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
    c_timer_load: cover property (strobes_in != 3'b000 ##1 $changed(converter_channel_b_code_out));
    c_write_load: cover property (hi_wr ##1 $changed(converter_channel_a_code_out));
    c_enable: cover property ($rose(conv1_enable_out));
endmodule : dual_dac_data_update_control_asserts
bind dual_dac_data_update_control dual_dac_data_update_control_asserts u_dual_dac_data_update_control_asserts (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sfr_req_in(sfr_req_in), .strobes_in(strobes_in),
    .sfr_rdata_out(sfr_rdata_out), .sfr_rvalid_out(sfr_rvalid_out),
    .converter_channel_a_code_out(converter_channel_a_code_out),
    .converter_channel_b_code_out(converter_channel_b_code_out),
    .conv0_enable_out(conv0_enable_out), .conv1_enable_out(conv1_enable_out));

// ==== verification/dual_dac_data_update_control_test.sv ====
// Self-checking bench of the dual converter update block
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module dual_dac_data_update_control_test;
    import dac_update_pkg::*;
    localparam logic [7:0] PA = `CONV_PAGE_A;
    localparam logic [7:0] PB = `CONV_PAGE_B;
    localparam logic [7:0] LO = `CONV_ADDR_LOW;
    localparam logic [7:0] HI = `CONV_ADDR_HIGH;
    localparam logic [7:0] CT = `CONV_ADDR_CTRL;
    logic             clk_sys_in = 1'b0;
    logic             rstn_in    = 1'b0;
    sfr_req_type      req        = '0;
    timer_strobe_type strobes;
    logic [7:0]       rdata;
    logic             rvalid;
    logic [11:0]      code_a;
    logic [11:0]      code_b;
    logic             en_a;
    logic             en_b;
    int               fails      = 0;
    int               samples_checked = 0;
    int               cycles     = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    timer_overflow_model u_timer_overflow_model (.strobes_out(strobes), .clk_sys_in(clk_sys_in));
    dual_dac_data_update_control u_dual_dac_data_update_control (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sfr_req_in(req), .strobes_in(strobes),
        .sfr_rdata_out(rdata), .sfr_rvalid_out(rvalid), .converter_channel_a_code_out(code_a),
        .converter_channel_b_code_out(code_b), .conv0_enable_out(en_a), .conv1_enable_out(en_b));
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Strobe dropped after its edge, then one idle edge so the next request starts clean
    task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        req = '{addr: ad, page: pg, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk_sys_in);
        #1 req.wr = 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
        req = '{addr: ad, page: pg, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk_sys_in);
        #1 req.rd = 1'b0;
        chk({11'h000, rvalid}, 12'h001);
        chk({4'h0, rdata}, {4'h0, exp});
        @(posedge clk_sys_in);
        #1;
    endtask : rd
    function automatic logic [11:0] place(input logic [2:0] f, input logic [7:0] h, input logic [7:0] l);
        logic [15:0] both;
        both = {h, l} >> (f[2] ? 3'd4 : {1'b0, f[1:0]});
        return both[11:0];
    endfunction : place
    task automatic t_reset;
        for (int p = 0; p < 2; p++) begin
            rd(p[7:0], CT, `CONV_CTRL_RESET);
            rd(p[7:0], LO, `CONV_LOW_RESET);
            rd(p[7:0], HI, `CONV_HIGH_RESET);
        end
        rd(8'h02, CT, 8'h00);
        chk(code_a | code_b, `CONV_CODE_RESET);
        chk({10'h000, en_a, en_b}, 12'h000);
    endtask : t_reset
    task automatic t_formats;
        logic [11:0] exp_a;
        exp_a = 12'h000;
        for (int f = 0; f < 8; f++) begin
            wr(PA, CT, 8'he0 | f[7:0]);
            rd(PA, CT, 8'h80 | f[7:0]);
            chk({11'h000, en_a}, 12'h001);
            wr(PA, LO, 8'h5a + f[7:0]);
            chk(code_a, exp_a);
            wr(PA, HI, 8'hc3 ^ f[7:0]);
            exp_a = place(f[2:0], 8'hc3 ^ f[7:0], 8'h5a + f[7:0]);
            chk(code_a, exp_a);
            u_timer_overflow_model.pulse(3'b111);
            chk(code_a, exp_a);
        end
        wr(PA, CT, 8'h00);
        chk({11'h000, en_a}, 12'h000);
        chk(code_b, 12'h000);
    endtask : t_formats
    task automatic t_range;
        wr(PA, LO, 8'hff);
        wr(PA, HI, 8'hff);
        chk(code_a, 12'hfff);
        wr(PA, LO, 8'h00);
        wr(PA, HI, 8'hf0);
        chk(code_a, 12'h000);
        rd(PA, HI, 8'hf0);
        wr(8'h02, HI, 8'h55);
        chk(code_a, 12'h000);
    endtask : t_range
    task automatic t_timers;
        logic [2:0]  sel [3] = '{3'b010, 3'b001, 3'b100};
        logic [11:0] exp_b;
        exp_b = 12'h000;
        for (int m = 1; m < 4; m++) begin
            wr(PB, CT, {3'b100, m[1:0], 3'b100});
            chk({11'h000, en_b}, 12'h001);
            wr(PB, LO, {m[3:0], 4'h0});
            wr(PB, HI, {4'ha, m[3:0]});
            chk(code_b, exp_b);
            u_timer_overflow_model.pulse(~sel[m-1]);
            chk(code_b, exp_b);
            u_timer_overflow_model.pulse(sel[m-1]);
            exp_b = place(3'b100, {4'ha, m[3:0]}, {m[3:0], 4'h0});
            chk(code_b, exp_b);
        end
        rd(PB, HI, 8'ha3);
        rd(PB, CT, 8'h9c);
    endtask : t_timers
    task automatic stop_test;
        $display("Checked %0d values, %0d mismatches", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys_in);
        #1 rstn_in = 1'b1;
        t_reset();
        t_formats();
        t_range();
        t_timers();
        stop_test();
    end
endmodule : dual_dac_data_update_control_test

// ==== verification/timer_overflow_model.sv ====
// Timer overflow strobe source facing the converter update block
`timescale 1ns/10ps
module timer_overflow_model (
    output dac_update_pkg::timer_strobe_type strobes_out,
    input  wire logic                        clk_sys_in
);
    import dac_update_pkg::*;
    initial strobes_out = '0;
    // One-cycle strobe, launched just after an edge
    task automatic pulse(input logic [2:0] which);
        strobes_out = which;
        @(posedge clk_sys_in);
        #1 strobes_out = '0;
        // Idle edge keeps back-to-back pulses apart
        @(posedge clk_sys_in);
        #1;
    endtask : pulse
endmodule : timer_overflow_model
